// File: rtl/mccd_core.sv
// execution of clear, call-via-working and decrement instructions behind apb
`timescale 1ns/1ps
`include "mccd_cfg.svh"

// Behaviour
// - watchdog clear instruction pulses a clear of the watchdog counter
// - same instruction clears the watchdog prescaler in that same cycle
// - same instruction sets timeout and powerdown status bits to one
// - call via working pushes program counter plus one onto return stack top
// - then pc low byte from working, pc bits 14..8 from latch bits 6..0
// - call via working takes two cycles, status flags untouched
// - clear file writes zero to file register 0..127 and sets zero flag
// - clear working writes zero to working register and sets zero flag
// - decrement subtracts one, destination bit picks working or file
// - decrement-and-skip subtracts one, routes by destination, flags untouched
// - zero result of decrement-and-skip discards next instruction, two cycles
module mccd_core (
  // clock and reset
  input  wire logic        CLOCK_I,
  input  wire logic        RESETN_I,
  // apb slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // watchdog side
  output logic             WDT_CLEAR_O,
  output logic             PRESCALER_CLEAR_O,
  // status and progress
  output logic             TIMEOUT_STATUS_N_O,
  output logic             POWERDOWN_STATUS_N_O,
  output logic             BUSY_O
);

  // state
  mccd_pkg::mccd_state_t  state_ff;
  mccd_pkg::mccd_state_t  nxt_state;
  mccd_pkg::mccd_opcode_t instr_ff;
  mccd_pkg::mccd_pc_t     pc_ff;
  mccd_pkg::mccd_pc_t     nxt_pc;
  mccd_pkg::mccd_pc_t     stack_top_ff;
  logic [7:0]             work_ff;
  logic [6:0]             latch_ff;
  logic [6:0]             faddr_ff;
  logic                   zero_ff;
  logic                   to_n_ff;
  logic                   pd_n_ff;
  logic                   skip_ff;
  logic                   busy_ff;
  logic                   wdclr_ff;
  logic                   prsclr_ff;
  logic                   pready_ff;
  logic                   pslverr_ff;
  logic [31:0]            prdata_ff;
  // file registers, no reset: contents are undefined after power-up
  logic [7:0]             file_mem [0:`MCCD_FILE_WORDS-1];

  // shared helpers
  function automatic logic is_zero8(input logic [7:0] v);
    return (v == 8'h00);
  endfunction

  function automatic logic op_match(input mccd_pkg::mccd_opcode_t op,
                                    input mccd_pkg::mccd_opcode_t msk,
                                    input mccd_pkg::mccd_opcode_t val);
    return ((op & msk) == val);
  endfunction

  // instruction decode
  wire        in_exec    = (state_ff == mccd_pkg::MCCD_EXEC);
  wire        in_idle    = (state_ff == mccd_pkg::MCCD_IDLE);
  wire        op_wdclr   = op_match(instr_ff, `MCCD_MSK_WDCLR, `MCCD_OPM_WDCLR);
  wire        op_call_via_working_op   = op_match(instr_ff, `MCCD_MSK_CALL_VIA_WORKING_OP, `MCCD_OPM_CALL_VIA_WORKING_OP);
  wire        op_clear_working_op    = op_match(instr_ff, `MCCD_MSK_CLEAR_WORKING_OP, `MCCD_OPM_CLEAR_WORKING_OP);
  wire        op_clear_file_op    = op_match(instr_ff, `MCCD_MSK_CLEAR_FILE_OP, `MCCD_OPM_CLEAR_FILE_OP);
  wire        op_complement_file_op    = op_match(instr_ff, `MCCD_MSK_COMPLEMENT_FILE_OP, `MCCD_OPM_COMPLEMENT_FILE_OP);
  wire        op_decrement_file_op    = op_match(instr_ff, `MCCD_MSK_DECREMENT_FILE_OP, `MCCD_OPM_DECREMENT_FILE_OP);
  wire        op_decrement_skip_zero_op  = op_match(instr_ff, `MCCD_MSK_DECREMENT_SKIP_ZERO_OP, `MCCD_OPM_DECREMENT_SKIP_ZERO_OP);
  wire        dest_file  = instr_ff[`MCCD_FLD_DEST];
  wire [6:0]  f_addr     = instr_ff[`MCCD_FLD_FMSB:0];

  // datapath
  wire [7:0]  f_val      = file_mem[f_addr];
  wire [7:0]  f_dec      = f_val - 8'h01;
  wire [7:0]  f_comp     = ~f_val;
  wire        op_dst     = op_complement_file_op | op_decrement_file_op | op_decrement_skip_zero_op;
  wire        op_clear   = op_clear_file_op | op_clear_working_op;
  wire [7:0]  result     = op_clear ? 8'h00 : (op_complement_file_op ? f_comp : f_dec);
  wire        res_zero   = is_zero8(result);
  // destination select by the d bit
  wire        wr_work    = in_exec & ((op_dst & ~dest_file) | op_clear_working_op);
  wire        wr_file    = in_exec & ((op_dst & dest_file) | op_clear_file_op);
  // skip only when the decremented value reaches zero
  wire        skip_now   = in_exec & op_decrement_skip_zero_op & res_zero;
  wire        two_cycle  = in_exec & (op_call_via_working_op | skip_now);
  wire [14:0] pc_inc     = pc_ff + 15'h0001;
  wire [14:0] pc_inc2    = pc_ff + 15'h0002;
  wire [14:0] call_tgt   = {latch_ff, work_ff};

  // apb decode; one wait cycle so read data comes from a flop
  wire        apb_first  = PSEL_I & PENABLE_I & ~pready_ff;
  wire        apb_commit = PSEL_I & PENABLE_I & pready_ff & ~pslverr_ff;
  wire        bus_wr     = apb_commit & PWRITE_I;
  wire        hit_issue  = (PADDR_I == `MCCD_OFF_ISSUE);
  wire        hit_work   = (PADDR_I == `MCCD_OFF_WORK);
  wire        hit_status = (PADDR_I == `MCCD_OFF_STATUS);
  wire        hit_pc     = (PADDR_I == `MCCD_OFF_PC);
  wire        hit_latch  = (PADDR_I == `MCCD_OFF_LATCH);
  wire        hit_stack  = (PADDR_I == `MCCD_OFF_STACK);
  wire        hit_faddr  = (PADDR_I == `MCCD_OFF_FADDR);
  wire        hit_fdata  = (PADDR_I == `MCCD_OFF_FDATA);
  wire        wr_issue   = bus_wr & hit_issue;
  wire        bwr_work   = bus_wr & hit_work;
  wire        bwr_status = bus_wr & hit_status;
  wire        bwr_pc     = bus_wr & hit_pc;
  wire        bwr_latch  = bus_wr & hit_latch;
  wire        bwr_faddr  = bus_wr & hit_faddr;
  wire        bwr_fdata  = bus_wr & hit_fdata;

  logic [31:0] rd_mux;
  logic        rd_err;
  wire  [31:0] status_word = {22'h000000, skip_ff, busy_ff, 3'h0,
                              to_n_ff, pd_n_ff, 2'h0, zero_ff};

  // read mux and error; writes while busy, issue included, are refused too
  always_comb begin
    rd_mux = 32'h00000000;
    rd_err = 1'b0;
    if (hit_issue) begin
      rd_mux = {18'h00000, instr_ff};
      rd_err = PWRITE_I & busy_ff;
    end else if (hit_work) begin
      rd_mux = {24'h000000, work_ff};
      rd_err = PWRITE_I & busy_ff;
    end else if (hit_status) begin
      rd_mux = status_word;
      rd_err = PWRITE_I & busy_ff;
    end else if (hit_pc) begin
      rd_mux = {17'h00000, pc_ff};
      rd_err = PWRITE_I & busy_ff;
    end else if (hit_latch) begin
      rd_mux = {25'h0000000, latch_ff};
      rd_err = PWRITE_I & busy_ff;
    end else if (hit_stack) begin
      rd_mux = {17'h00000, stack_top_ff};
      rd_err = PWRITE_I;
    end else if (hit_faddr) begin
      rd_mux = {25'h0000000, faddr_ff};
      rd_err = PWRITE_I & busy_ff;
    end else if (hit_fdata) begin
      rd_mux = {24'h000000, file_mem[faddr_ff]};
      rd_err = PWRITE_I & busy_ff;
    end else begin
      rd_err = 1'b1;
    end
  end

  // sequencer
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      mccd_pkg::MCCD_IDLE: begin
        if (wr_issue) begin
          nxt_state = mccd_pkg::MCCD_EXEC;
        end
      end
      mccd_pkg::MCCD_EXEC: begin
        if (two_cycle) begin
          nxt_state = mccd_pkg::MCCD_FLUSH;
        end else begin
          nxt_state = mccd_pkg::MCCD_IDLE;
        end
      end
      mccd_pkg::MCCD_FLUSH: begin
        nxt_state = mccd_pkg::MCCD_IDLE;
      end
      default: begin
        nxt_state = mccd_pkg::MCCD_IDLE;
      end
    endcase
  end

  // program counter next value
  always_comb begin
    nxt_pc = pc_ff;
    if (in_exec) begin
      if (op_call_via_working_op) begin
        nxt_pc = call_tgt;
      end else if (skip_now) begin
        nxt_pc = pc_inc2;
      end else begin
        nxt_pc = pc_inc;
      end
    end else if (bwr_pc) begin
      nxt_pc = PWDATA_I[14:0];
    end
  end

  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      state_ff <= mccd_pkg::MCCD_IDLE;
      busy_ff  <= 1'b0;
      instr_ff <= 14'h0000;
      pc_ff    <= `MCCD_RST_PC;
    end else begin
      state_ff <= nxt_state;
      busy_ff  <= (nxt_state != mccd_pkg::MCCD_IDLE);
      pc_ff    <= nxt_pc;
      if (wr_issue & in_idle) begin
        instr_ff <= PWDATA_I[13:0];
      end
    end
  end

  // return stack top holds the pushed return address
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      stack_top_ff <= `MCCD_RST_PC;
    end else if (in_exec & op_call_via_working_op) begin
      stack_top_ff <= pc_inc;
    end
  end

  // working register
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      work_ff <= `MCCD_RST_WORK;
    end else if (wr_work) begin
      work_ff <= result;
    end else if (bwr_work) begin
      work_ff <= PWDATA_I[7:0];
    end
  end

  // zero flag; decrement-and-skip and call leave it alone
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      zero_ff <= `MCCD_RST_ZERO;
    end else if (in_exec & op_clear) begin
      zero_ff <= 1'b1;
    end else if (in_exec & (op_complement_file_op | op_decrement_file_op)) begin
      zero_ff <= res_zero;
    end else if (bwr_status) begin
      zero_ff <= PWDATA_I[`MCCD_ST_ZERO];
    end
  end

  // timeout and powerdown status
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      to_n_ff <= `MCCD_RST_TO_N;
      pd_n_ff <= `MCCD_RST_PD_N;
    end else if (in_exec & op_wdclr) begin
      to_n_ff <= 1'b1;
      pd_n_ff <= 1'b1;
    end else if (bwr_status) begin
      to_n_ff <= PWDATA_I[`MCCD_ST_TO_N];
      pd_n_ff <= PWDATA_I[`MCCD_ST_PD_N];
    end
  end

  // watchdog clears leave together so counter and prescaler never drift apart
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      wdclr_ff  <= 1'b0;
      prsclr_ff <= 1'b0;
    end else begin
      wdclr_ff  <= in_exec & op_wdclr;
      prsclr_ff <= in_exec & op_wdclr;
    end
  end

  // skip indicator, kept until the next instruction executes
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      skip_ff <= 1'b0;
    end else if (in_exec) begin
      skip_ff <= skip_now;
    end
  end

  // upper address latch
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      latch_ff <= `MCCD_RST_LATCH;
    end else if (bwr_latch) begin
      latch_ff <= PWDATA_I[6:0];
    end
  end

  // file pointer
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      faddr_ff <= 7'h00;
    end else if (bwr_faddr) begin
      faddr_ff <= PWDATA_I[6:0];
    end
  end

  // file register writes; core and bus never collide since bus is refused while busy
  always_ff @(posedge CLOCK_I) begin
    if (wr_file) begin
      file_mem[f_addr] <= result;
    end else if (bwr_fdata) begin
      file_mem[faddr_ff] <= PWDATA_I[7:0];
    end
  end

  // apb answer
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= apb_first;
      pslverr_ff <= apb_first & rd_err;
    end
  end

  // read data caught in the first access cycle, already stable when pready shows
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      prdata_ff <= 32'h00000000;
    end else if (apb_first & ~PWRITE_I) begin
      prdata_ff <= rd_err ? 32'h00000000 : rd_mux;
    end
  end

  assign PRDATA_O             = prdata_ff;
  assign PREADY_O             = pready_ff;
  assign PSLVERR_O            = pslverr_ff;
  assign WDT_CLEAR_O          = wdclr_ff;
  assign PRESCALER_CLEAR_O    = prsclr_ff;
  assign TIMEOUT_STATUS_N_O   = to_n_ff;
  assign POWERDOWN_STATUS_N_O = pd_n_ff;
  assign BUSY_O               = busy_ff;

endmodule

// File: shared/mccd_cfg.svh
// constants for the clear, call and decrement execution block
`ifndef MCCD_CFG_SVH
`define MCCD_CFG_SVH
// register byte offsets
`define MCCD_OFF_ISSUE   8'h00
`define MCCD_OFF_WORK    8'h04
`define MCCD_OFF_STATUS  8'h08
`define MCCD_OFF_PC      8'h0C
`define MCCD_OFF_LATCH   8'h10
`define MCCD_OFF_STACK   8'h14
`define MCCD_OFF_FADDR   8'h18
`define MCCD_OFF_FDATA   8'h1C
// status field positions
`define MCCD_ST_ZERO     0
`define MCCD_ST_PD_N     3
`define MCCD_ST_TO_N     4
`define MCCD_ST_BUSY     8
`define MCCD_ST_SKIP     9
// reset values
`define MCCD_RST_WORK    8'h00
`define MCCD_RST_PC      15'h0000
`define MCCD_RST_LATCH   7'h00
`define MCCD_RST_ZERO    1'b0
`define MCCD_RST_TO_N    1'b1
`define MCCD_RST_PD_N    1'b1
// opcode match values and masks
`define MCCD_OPM_WDCLR   14'h0064
`define MCCD_MSK_WDCLR   14'h3FFF
`define MCCD_OPM_CALL_VIA_WORKING_OP   14'h000A
`define MCCD_MSK_CALL_VIA_WORKING_OP   14'h3FFF
`define MCCD_OPM_CLEAR_WORKING_OP    14'h0100
`define MCCD_MSK_CLEAR_WORKING_OP    14'h3FFC
`define MCCD_OPM_CLEAR_FILE_OP    14'h0180
`define MCCD_MSK_CLEAR_FILE_OP    14'h3F80
`define MCCD_OPM_COMPLEMENT_FILE_OP    14'h0900
`define MCCD_MSK_COMPLEMENT_FILE_OP    14'h3F00
`define MCCD_OPM_DECREMENT_FILE_OP    14'h0300
`define MCCD_MSK_DECREMENT_FILE_OP    14'h3F00
`define MCCD_OPM_DECREMENT_SKIP_ZERO_OP  14'h0B00
`define MCCD_MSK_DECREMENT_SKIP_ZERO_OP  14'h3F00
// opcode fields
`define MCCD_FLD_DEST    7
`define MCCD_FLD_FMSB    6
// file register count
`define MCCD_FILE_WORDS  128
`endif

// File: shared/mccd_pkg.sv
// types for the clear, call and decrement execution block
package mccd_pkg;
  typedef enum logic [2:0] {
    MCCD_IDLE  = 3'b001,
    MCCD_EXEC  = 3'b010,
    MCCD_FLUSH = 3'b100
  } mccd_state_t;
  typedef logic [13:0] mccd_opcode_t;
  typedef logic [14:0] mccd_pc_t;
endpackage

// File: test/mccd_core_props.sv
// port assertions for the clear, call and decrement block
`timescale 1ns/1ps
module mccd_core_props (
  // clock and reset
  input wire logic        CLOCK_I,
  input wire logic        RESETN_I,
  // apb
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [7:0]  PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  // core outputs
  input wire logic        WDT_CLEAR_O,
  input wire logic        PRESCALER_CLEAR_O,
  input wire logic        TIMEOUT_STATUS_N_O,
  input wire logic        POWERDOWN_STATUS_N_O,
  input wire logic        BUSY_O
);
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!RESETN_I);
  a_clr_pulse: assert property (WDT_CLEAR_O |=> !WDT_CLEAR_O)
    else $error("watchdog clear longer than one cycle");
  a_clr_cause: assert property (WDT_CLEAR_O |-> !BUSY_O && $past(BUSY_O))
    else $error("watchdog clear without an executing instruction");
  a_clr_pair: assert property (WDT_CLEAR_O == PRESCALER_CLEAR_O)
    else $error("prescaler clear not with counter clear");
  a_clr_status: assert property (WDT_CLEAR_O |-> TIMEOUT_STATUS_N_O && POWERDOWN_STATUS_N_O)
    else $error("status bits not set by watchdog clear");
  a_to_cause: assert property ($rose(TIMEOUT_STATUS_N_O) |-> WDT_CLEAR_O || $past(PREADY_O))
    else $error("timeout status rose without cause");
  a_busy_len: assert property ($rose(BUSY_O) |-> ##[1:2] !BUSY_O)
    else $error("busy longer than two cycles");
  a_ready_wait: assert property (PSEL_I && $rose(PENABLE_I) |-> !PREADY_O ##1 PREADY_O)
    else $error("apb wait state count wrong");
  a_ready_one: assert property (PREADY_O |=> !PREADY_O)
    else $error("ready held over one cycle");
  a_err_ready: assert property (PSLVERR_O |-> PREADY_O)
    else $error("error without ready");
  cover property (WDT_CLEAR_O);
  cover property ($rose(BUSY_O) ##1 BUSY_O);
  cover property (PREADY_O && PSLVERR_O);
endmodule
bind mccd_core mccd_core_props u_chk (.CLOCK_I, .RESETN_I, .PSEL_I, .PENABLE_I, .PWRITE_I,
  .PADDR_I, .PWDATA_I, .PRDATA_O, .PREADY_O, .PSLVERR_O, .WDT_CLEAR_O, .PRESCALER_CLEAR_O,
  .TIMEOUT_STATUS_N_O, .POWERDOWN_STATUS_N_O, .BUSY_O);

// File: test/mcu_clear_call_decrement_ops_tb.sv
// self-checking bench for the clear, call and decrement block
`timescale 1ns/1ps
`include "mccd_cfg.svh"
module mcu_clear_call_decrement_ops_tb;
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [7:0]  padr = 8'h00;
  logic [31:0] pwd = 32'h0, prd, rd, seed = 32'h5C86;
  logic        prdy, perr, wdc, psc, ton, pdn, busy, er, z, d, tp;
  logic [7:0]  w, v, r, f;
  logic [14:0] pc, stk = 15'h0000;
  logic [6:0]  lat;
  logic [13:0] op;
  logic [13:0] opv [7] = '{`MCCD_OPM_COMPLEMENT_FILE_OP, `MCCD_OPM_DECREMENT_FILE_OP, `MCCD_OPM_DECREMENT_SKIP_ZERO_OP,
    `MCCD_OPM_CLEAR_FILE_OP, `MCCD_OPM_CLEAR_WORKING_OP, `MCCD_OPM_CALL_VIA_WORKING_OP, `MCCD_OPM_WDCLR};
  int          n_errors = 0, n_checks = 0, nb, nw, np, k;
  always #4 clk = ~clk;
  mccd_core dut_u (.CLOCK_I(clk), .RESETN_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy),
    .PSLVERR_O(perr), .WDT_CLEAR_O(wdc), .PRESCALER_CLEAR_O(psc),
    .TIMEOUT_STATUS_N_O(ton), .POWERDOWN_STATUS_N_O(pdn), .BUSY_O(busy));
  function automatic void step();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // request held up to the rising edge that samples pready high; answer taken there
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dt);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= wr;
    padr <= a;
    pwd <= dt;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (prdy !== 1'b1);
    rd = prd;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    chk(rd & m, exp);
  endtask
  // fixed four-cycle window covers the longest busy span
  task automatic issue(input logic [13:0] o, input int eb, input int ew);
    apb(1'b1, `MCCD_OFF_ISSUE, {18'h0, o});
    chk({31'h0, er}, 32'h0);
    nb = 0;
    nw = 0;
    np = 0;
    repeat (4) begin
      @(negedge clk);
      nb += int'(busy === 1'b1);
      nw += int'(wdc === 1'b1);
      np += int'(psc === 1'b1);
    end
    chk(nb, eb);
    chk(nw, ew);
    chk(np, ew);
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    give_verdict();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(`MCCD_OFF_WORK, 32'h0, '1);
    rdchk(`MCCD_OFF_PC, 32'h0, '1);
    rdchk(`MCCD_OFF_STATUS, 32'h18, '1);
    rdchk(`MCCD_OFF_STACK, 32'h0, '1);
    $display("test reset done");
    apb(1'b0, 8'h20, 32'h0);
    chk({er, rd[30:0]}, 32'h80000000);
    apb(1'b1, `MCCD_OFF_STACK, 32'h1);
    chk({31'h0, er}, 32'h1);
    issue(14'h0000, 1, 0);
    rdchk(`MCCD_OFF_PC, 32'h1, '1);
    $display("test refusal done");
    for (int i = 0; i < 70; i++) begin
      step();
      w = seed[7:0];
      v = seed[15:8];
      f = {1'b0, seed[22:16]};
      lat = seed[29:23];
      z = seed[30];
      d = seed[31];
      step();
      pc = seed[14:0];
      tp = seed[15];
      k = int'(seed[31:16] % 7);
      if (seed[17]) begin
        v = {7'h0, seed[18]};
      end
      apb(1'b1, `MCCD_OFF_FADDR, {24'h0, f});
      apb(1'b1, `MCCD_OFF_FDATA, {24'h0, v});
      apb(1'b1, `MCCD_OFF_WORK, {24'h0, w});
      apb(1'b1, `MCCD_OFF_LATCH, {25'h0, lat});
      apb(1'b1, `MCCD_OFF_STATUS, {27'h0, tp, tp, 2'b00, z});
      apb(1'b1, `MCCD_OFF_PC, {17'h0, pc});
      op = opv[k] | ((k < 3) ? {6'h00, d, f[6:0]} : (k == 3) ? {7'h00, f[6:0]} : 14'h0);
      r = (k == 0) ? ~v : (k < 3) ? v - 8'h01 : 8'h00;
      issue(op, (k == 5 || (k == 2 && r == 8'h00)) ? 2 : 1, (k == 6) ? 1 : 0);
      rdchk(`MCCD_OFF_WORK, {24'h0, (k == 4 || (k < 3 && !d)) ? r : w}, '1);
      rdchk(`MCCD_OFF_FDATA, {24'h0, (k == 3 || (k < 3 && d)) ? r : v}, '1);
      rdchk(`MCCD_OFF_STATUS, {22'h0, (k == 2 && r == 8'h00), 1'b0, 3'h0,
        (k == 6) ? 2'b11 : {tp, tp}, 2'b00,
        (k < 5 && k != 2) ? (r == 8'h00) : z}, 32'h319);
      chk({30'h0, ton, pdn}, {30'h0, (k == 6) ? 2'b11 : {tp, tp}});
      if (k == 5) begin
        stk = pc + 15'h0001;
        pc = {lat, w};
      end else begin
        pc = pc + ((k == 2 && r == 8'h00) ? 15'h0002 : 15'h0001);
      end
      rdchk(`MCCD_OFF_PC, {17'h0, pc}, '1);
      rdchk(`MCCD_OFF_STACK, {17'h0, stk}, '1);
    end
    $display("test random ops done");
    give_verdict();
  end
endmodule
